// >>> hw/sdac_pkg.sv
// sdac_pkg: register map, field positions and reset values of the converter control block
// assumes APB with 32-bit data, one aligned word per register
package sdac_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_GLOBAL_CTL = 8'h00;
	localparam logic [7:0] ADDR_CHANNEL_CTL = 8'h04;
	localparam logic [7:0] ADDR_RESULT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
	localparam logic [7:0] ADDR_CORE_CTL = 8'h18;
	// global control fields
	localparam int GC_PREDIV_LSB = 9;
	localparam int GC_LOWPWR_BIT = 8;
	localparam int GC_DIV_LSB = 6;
	localparam int GC_SRC_LSB = 4;
	localparam int GC_BUFON_BIT = 3;
	localparam int GC_REFON_BIT = 2;
	localparam int GC_OVIE_BIT = 1;
	localparam logic [15:0] GC_WRITE_MASK = 16'h0FFE;
	localparam logic [15:0] GC_RESET = 16'h0000;
	// channel control fields
	localparam int CC_BUF_LSB = 13;
	localparam int CC_UNI_BIT = 12;
	localparam int CC_XOSR_BIT = 11;
	localparam int CC_SNGL_BIT = 10;
	localparam int CC_OSR_LSB = 8;
	localparam int CC_LSBTOG_BIT = 7;
	localparam int CC_LSBACC_BIT = 6;
	localparam int CC_OVF_BIT = 5;
	localparam int CC_DF_BIT = 4;
	localparam int CC_IE_BIT = 3;
	localparam int CC_IFG_BIT = 2;
	localparam int CC_SC_BIT = 1;
	localparam logic [15:0] CC_WRITE_MASK = 16'h7FFE;
	localparam logic [15:0] CC_RESET = 16'h0000;
	// interrupt status layout
	localparam int IRQ_CONV_BIT = 0;
	localparam int IRQ_OVF_BIT = 1;
	localparam int IRQ_W = 2;
	// core control: bit 0 is the processor global interrupt enable
	localparam int CORE_GIE_BIT = 0;
	// pre-divider ratios
	localparam logic [5:0] PREDIV_1 = 6'h01;
	localparam logic [5:0] PREDIV_3 = 6'h03;
	localparam logic [5:0] PREDIV_16 = 6'h10;
	localparam logic [5:0] PREDIV_48 = 6'h30;
	typedef enum logic [1:0] {SDAC_SRC_MAIN, SDAC_SRC_SUB, SDAC_SRC_AUX, SDAC_SRC_EXT} sdac_src_t;
endpackage : sdac_pkg

// >>> hw/sdac_clk_if.sv
// sdac_clk_if: divider settings passed from the register file to the clock divider
// assumes the producer drives the select fields from flip-flops; src_tick comes straight from the tick inputs
`timescale 1ns/1ps
interface sdac_clk_if;
	logic [2:0] clock_prediv_sel;
	logic [1:0] clock_div_sel;
	logic [3:0] src_tick;
	logic [1:0] clock_source_sel;
	logic mod_tick;
	modport ctl (output clock_prediv_sel, output clock_div_sel, output clock_source_sel,
		output src_tick, input mod_tick);
	modport div (input clock_prediv_sel, input clock_div_sel, input clock_source_sel,
		input src_tick, output mod_tick);
endinterface : sdac_clk_if

// >>> hw/sdac_clk_div.sv
// sdac_clk_div: source select, pre-divider and second divider for the modulator tick
// assumes source clocks arrive as single-cycle ticks synchronous to ref_clk
`timescale 1ns/1ps
module sdac_clk_div (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// settings and tick
	sdac_clk_if.div cfg
);
	typedef struct packed {
		logic [5:0] pre_cnt;
		logic [2:0] div_cnt;
		logic tick;
	} sdac_div_state_t;
	sdac_div_state_t state_reg, state_next;
	logic src;
	logic [5:0] pre_ratio;
	logic [2:0] div_last;

	always_comb begin
		src = cfg.src_tick[cfg.clock_source_sel];
		unique case (cfg.clock_prediv_sel)
			3'h0: pre_ratio = sdac_pkg::PREDIV_1;
			3'h1: pre_ratio = sdac_pkg::PREDIV_3;
			3'h2: pre_ratio = sdac_pkg::PREDIV_16;
			3'h3: pre_ratio = sdac_pkg::PREDIV_48;
			default: pre_ratio = sdac_pkg::PREDIV_1; // reserved codes held at /1
		endcase
		div_last = 3'((4'h1 << cfg.clock_div_sel) - 4'h1);
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (src) begin
			if (state_reg.pre_cnt >= pre_ratio - 6'h01) begin
				state_next.pre_cnt = 6'h00;
				if (state_reg.div_cnt >= div_last) begin
					state_next.div_cnt = 3'h0;
					state_next.tick = 1'b1;
				end else begin
					state_next.div_cnt = state_reg.div_cnt + 3'h1;
				end
			end else begin
				state_next.pre_cnt = state_reg.pre_cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign cfg.mod_tick = state_reg.tick;

	property p_tick_needs_src;
		@(posedge ref_clk) disable iff (!resetn) cfg.mod_tick |-> $past(src);
	endproperty
	a_tick_needs_src: assert property (p_tick_needs_src) else $error("tick without source");

	property p_div1_passes;
		@(posedge ref_clk) disable iff (!resetn)
		(src && cfg.clock_prediv_sel == 3'h0 && cfg.clock_div_sel == 2'h0
			&& state_reg.pre_cnt == 6'h00 && state_reg.div_cnt == 3'h0) |=> cfg.mod_tick;
	endproperty
	a_div1_passes: assert property (p_div1_passes) else $error("undivided tick lost");
endmodule : sdac_clk_div

// >>> hw/sdac_irq_bit.sv
// sdac_irq_bit: one sticky flag, set by hardware, cleared by software, set wins
// assumes set and clear are single-cycle pulses
`timescale 1ns/1ps
module sdac_irq_bit (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// control
	input wire logic set_pulse,
	input wire logic clr_pulse,
	// flag
	output logic flag
);
	typedef struct packed {
		logic f;
	} sdac_flag_state_t;
	sdac_flag_state_t state_reg, state_next;

	always_comb begin
		state_next = state_reg;
		if (clr_pulse) begin
			state_next.f = 1'b0;
		end
		if (set_pulse) begin
			state_next.f = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign flag = state_reg.f;
endmodule : sdac_irq_bit

// >>> hw/sdac_ctrl.sv
// sdac_ctrl: APB register file and control logic of the single-channel converter
// assumes the converter core delivers results as one-cycle strobes on ref_clk
// and that the four clock sources arrive as ticks synchronous to ref_clk
//
// Contract
// - pre-divider /1 /3 /16 /48 from bits 11:9
// - second divider /1 /2 /4 /8 from bits 7:6
// - clock source chosen by bits 5:4
// - bit 8 selects reduced-power low-speed mode
// - overflow irq needs enable and global enable
// - bit 2 reference on, bit 3 buffer on
// - control bits 15:12 and 0 read zero
// - channel bits 14:13 set input buffer mode
// - channel bit 12: zero bipolar, one unipolar
// - bit 11 extends the oversampling ratio select
// - channel bits 7..1 layout, bit 0 zero
// - new result sets conversion done flag
// - unread result overwritten flags overflow
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module sdac_ctrl #(
	parameter int RES_W = 24
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// clock sources as ticks
	input wire logic main_clock_tick,
	input wire logic subsystem_clock_tick,
	input wire logic aux_clock_tick,
	input wire logic external_timer_clock_tick,
	// converter core
	input wire logic result_valid,
	input wire logic [RES_W-1:0] result_data,
	input wire logic conv_complete,
	output logic mod_tick,
	output logic low_power_mode_en,
	output logic ref_generator_on,
	output logic ref_buffer_on,
	output logic [1:0] input_buffer_mode,
	output logic unipolar_sel,
	output logic [2:0] osr_code,
	output logic single_conv_sel,
	output logic data_format_sel,
	output logic conv_start,
	// interrupt
	output logic irq
);
	typedef struct packed {
		logic [15:0] gctl;
		logic [15:0] cctl;
		logic [RES_W-1:0] result;
		logic unread;
		logic lsb_sel;
		logic [sdac_pkg::IRQ_W-1:0] irq_en;
		logic global_irq_enable;
		logic [31:0] rdata;
		logic irq;
		logic ack;
	} sdac_ctrl_state_t;
	sdac_ctrl_state_t state_reg, state_next;

	sdac_clk_if clk_bus ();
	logic wr_access, rd_access, addr_ok;
	logic result_read, conv_set, ovf_set, conv_clr, ovf_clr;
	logic conv_flag, ovf_flag;
	logic [sdac_pkg::IRQ_W-1:0] irq_status;
	logic [15:0] result_word;

	assign wr_access = psel && penable && pwrite && state_reg.ack;
	assign rd_access = psel && penable && !pwrite && !state_reg.ack;
	always_comb begin
		unique case (paddr)
			sdac_pkg::ADDR_GLOBAL_CTL, sdac_pkg::ADDR_CHANNEL_CTL, sdac_pkg::ADDR_RESULT,
			sdac_pkg::ADDR_IRQ_STATUS, sdac_pkg::ADDR_IRQ_CLEAR, sdac_pkg::ADDR_IRQ_ENABLE,
			sdac_pkg::ADDR_CORE_CTL: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	// one wait state: read data is registered in the first access cycle and
	// shown with pready in the second, so prdata stays a flop; unmapped gives an error
	assign pready = state_reg.ack;
	assign pslverr = psel && penable && state_reg.ack && !addr_ok;
	assign prdata = state_reg.rdata;

	// reading the result clears the done flag
	assign result_read = rd_access && paddr == sdac_pkg::ADDR_RESULT;
	assign conv_set = result_valid;
	assign ovf_set = result_valid && state_reg.unread && !result_read;
	// channel control writes of zero to a flag, or the clear register, clear it
	assign conv_clr = result_read
		|| (wr_access && paddr == sdac_pkg::ADDR_CHANNEL_CTL && !pwdata[sdac_pkg::CC_IFG_BIT])
		|| (wr_access && paddr == sdac_pkg::ADDR_IRQ_CLEAR && pwdata[sdac_pkg::IRQ_CONV_BIT]);
	assign ovf_clr =
		(wr_access && paddr == sdac_pkg::ADDR_CHANNEL_CTL && !pwdata[sdac_pkg::CC_OVF_BIT])
		|| (wr_access && paddr == sdac_pkg::ADDR_IRQ_CLEAR && pwdata[sdac_pkg::IRQ_OVF_BIT]);

	sdac_irq_bit u_conv_flag (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.set_pulse(conv_set),
		.clr_pulse(conv_clr),
		.flag(conv_flag)
	);
	sdac_irq_bit u_ovf_flag (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.set_pulse(ovf_set),
		.clr_pulse(ovf_clr),
		.flag(ovf_flag)
	);
	assign irq_status = {ovf_flag, conv_flag};

	// the upper 16 bits or lower 16 bits of the result, per access select
	assign result_word = state_reg.lsb_sel ? state_reg.result[15:0]
		: state_reg.result[RES_W-1 -: 16];

	always_comb begin
		state_next = state_reg;
		state_next.ack = psel && penable && !state_reg.ack;
		if (wr_access) begin
			unique case (paddr)
				sdac_pkg::ADDR_GLOBAL_CTL:
					state_next.gctl = pwdata[15:0] & sdac_pkg::GC_WRITE_MASK;
				sdac_pkg::ADDR_CHANNEL_CTL:
					state_next.cctl = pwdata[15:0] & sdac_pkg::CC_WRITE_MASK;
				sdac_pkg::ADDR_IRQ_ENABLE: state_next.irq_en = pwdata[sdac_pkg::IRQ_W-1:0];
				sdac_pkg::ADDR_CORE_CTL: state_next.global_irq_enable = pwdata[sdac_pkg::CORE_GIE_BIT];
				default: ;
			endcase
			if (paddr == sdac_pkg::ADDR_CHANNEL_CTL) begin
				state_next.lsb_sel = pwdata[sdac_pkg::CC_LSBACC_BIT];
			end
		end
		// flags live in their own flops; mirror them into the channel word
		state_next.cctl[sdac_pkg::CC_IFG_BIT] = conv_flag;
		state_next.cctl[sdac_pkg::CC_OVF_BIT] = ovf_flag;
		// single conversion ends by clearing the start bit
		if (conv_complete && state_reg.cctl[sdac_pkg::CC_SNGL_BIT]) begin
			state_next.cctl[sdac_pkg::CC_SC_BIT] = 1'b0;
		end
		if (result_read) begin
			state_next.unread = 1'b0;
			if (state_reg.cctl[sdac_pkg::CC_LSBTOG_BIT]) begin
				state_next.lsb_sel = !state_reg.lsb_sel;
			end
		end
		if (result_valid) begin
			state_next.result = result_data;
			state_next.unread = 1'b1;
		end
		state_next.cctl[sdac_pkg::CC_LSBACC_BIT] = state_next.lsb_sel;
		state_next.rdata = 32'h0000_0000;
		if (rd_access) begin
			unique case (paddr)
				sdac_pkg::ADDR_GLOBAL_CTL: state_next.rdata = {16'h0000, state_reg.gctl};
				sdac_pkg::ADDR_CHANNEL_CTL: begin
					state_next.rdata = {16'h0000, state_reg.cctl};
					state_next.rdata[sdac_pkg::CC_IFG_BIT] = conv_flag;
					state_next.rdata[sdac_pkg::CC_OVF_BIT] = ovf_flag;
				end
				sdac_pkg::ADDR_RESULT: state_next.rdata = {16'h0000, result_word};
				sdac_pkg::ADDR_IRQ_STATUS: state_next.rdata = 32'(irq_status);
				sdac_pkg::ADDR_IRQ_ENABLE: state_next.rdata = 32'(state_reg.irq_en);
				sdac_pkg::ADDR_CORE_CTL: state_next.rdata = 32'(state_reg.global_irq_enable);
				default: ;
			endcase
		end
		// overflow needs its own enable in the control word and the global enable
		state_next.irq = state_reg.global_irq_enable && (
			(ovf_flag && state_reg.gctl[sdac_pkg::GC_OVIE_BIT]
				&& state_reg.irq_en[sdac_pkg::IRQ_OVF_BIT])
			|| (conv_flag && state_reg.cctl[sdac_pkg::CC_IE_BIT]
				&& state_reg.irq_en[sdac_pkg::IRQ_CONV_BIT]));
	end

	// read data is captured in the first access cycle and stands through the second
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign clk_bus.clock_prediv_sel = state_reg.gctl[sdac_pkg::GC_PREDIV_LSB +: 3];
	assign clk_bus.clock_div_sel = state_reg.gctl[sdac_pkg::GC_DIV_LSB +: 2];
	assign clk_bus.clock_source_sel = state_reg.gctl[sdac_pkg::GC_SRC_LSB +: 2];
	assign clk_bus.src_tick = {external_timer_clock_tick, aux_clock_tick,
		subsystem_clock_tick, main_clock_tick};
	sdac_clk_div u_div (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.cfg(clk_bus)
	);
	assign mod_tick = clk_bus.mod_tick;

	assign low_power_mode_en = state_reg.gctl[sdac_pkg::GC_LOWPWR_BIT];
	assign ref_generator_on = state_reg.gctl[sdac_pkg::GC_REFON_BIT];
	assign ref_buffer_on = state_reg.gctl[sdac_pkg::GC_BUFON_BIT];
	assign input_buffer_mode = state_reg.cctl[sdac_pkg::CC_BUF_LSB +: 2];
	assign unipolar_sel = state_reg.cctl[sdac_pkg::CC_UNI_BIT];
	assign osr_code = {state_reg.cctl[sdac_pkg::CC_XOSR_BIT],
		state_reg.cctl[sdac_pkg::CC_OSR_LSB +: 2]};
	assign single_conv_sel = state_reg.cctl[sdac_pkg::CC_SNGL_BIT];
	assign data_format_sel = state_reg.cctl[sdac_pkg::CC_DF_BIT];
	assign conv_start = state_reg.cctl[sdac_pkg::CC_SC_BIT];
	assign irq = state_reg.irq;

	property p_gctl_reserved;
		@(posedge ref_clk) disable iff (!resetn)
		state_reg.gctl[15:12] == 4'h0 && !state_reg.gctl[0];
	endproperty
	a_gctl_reserved: assert property (p_gctl_reserved) else $error("reserved control bit set");

	property p_cctl_bit0;
		@(posedge ref_clk) disable iff (!resetn) !state_reg.cctl[0] && !state_reg.cctl[15];
	endproperty
	a_cctl_bit0: assert property (p_cctl_bit0) else $error("channel bit 0 set");

	property p_done_flag;
		@(posedge ref_clk) disable iff (!resetn) result_valid |=> conv_flag;
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("result did not set flag");

	property p_overflow;
		@(posedge ref_clk) disable iff (!resetn)
		(result_valid && state_reg.unread && !result_read) |=> ovf_flag;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overwrite missed overflow");

	property p_irq_gated;
		@(posedge ref_clk) disable iff (!resetn) irq |-> $past(state_reg.global_irq_enable);
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("irq without global enable");

	property p_ovf_irq;
		@(posedge ref_clk) disable iff (!resetn)
		(ovf_flag && state_reg.global_irq_enable && state_reg.gctl[sdac_pkg::GC_OVIE_BIT]
			&& state_reg.irq_en[sdac_pkg::IRQ_OVF_BIT]) |=> irq;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("enabled overflow gave no irq");

	property p_gctl_write;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_access && paddr == sdac_pkg::ADDR_GLOBAL_CTL) |=>
			low_power_mode_en == $past(pwdata[8]) && ref_buffer_on == $past(pwdata[3])
			&& ref_generator_on == $past(pwdata[2]);
	endproperty
	a_gctl_write: assert property (p_gctl_write) else $error("control write not applied");

	property p_cctl_write;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_access && paddr == sdac_pkg::ADDR_CHANNEL_CTL) |=>
			input_buffer_mode == $past(pwdata[14:13]) && unipolar_sel == $past(pwdata[12])
			&& osr_code[2] == $past(pwdata[11]);
	endproperty
	a_cctl_write: assert property (p_cctl_write) else $error("channel write not applied");

	property p_prediv_write;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_access && paddr == sdac_pkg::ADDR_GLOBAL_CTL) |=> clk_bus.clock_prediv_sel == $past(pwdata[11:9]);
	endproperty
	a_prediv_write: assert property (p_prediv_write) else $error("pre-divider not applied");

	property p_div_write;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_access && paddr == sdac_pkg::ADDR_GLOBAL_CTL) |=> clk_bus.clock_div_sel == $past(pwdata[7:6]);
	endproperty
	a_div_write: assert property (p_div_write) else $error("divider not applied");

	property p_src_write;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_access && paddr == sdac_pkg::ADDR_GLOBAL_CTL) |=> clk_bus.clock_source_sel == $past(pwdata[5:4]);
	endproperty
	a_src_write: assert property (p_src_write) else $error("source select not applied");

	property p_ref_write;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_access && paddr == sdac_pkg::ADDR_GLOBAL_CTL) |=> ref_generator_on == $past(pwdata[2]);
	endproperty
	a_ref_write: assert property (p_ref_write) else $error("reference switch not applied");

	property p_ovie_write;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_access && paddr == sdac_pkg::ADDR_GLOBAL_CTL) |=> state_reg.gctl[1] == $past(pwdata[1]);
	endproperty
	a_ovie_write: assert property (p_ovie_write) else $error("overflow enable not applied");

	property p_irq_gie_off;
		@(posedge ref_clk) disable iff (!resetn)
		!state_reg.global_irq_enable |=> !irq;
	endproperty
	a_irq_gie_off: assert property (p_irq_gie_off) else $error("irq with global enable off");

	property p_done_irq;
		@(posedge ref_clk) disable iff (!resetn)
		(conv_flag && state_reg.global_irq_enable && state_reg.cctl[sdac_pkg::CC_IE_BIT]
			&& state_reg.irq_en[sdac_pkg::IRQ_CONV_BIT]) |=> irq;
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("enabled done flag gave no irq");

	property p_unipolar_write;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_access && paddr == sdac_pkg::ADDR_CHANNEL_CTL) |=> unipolar_sel == $past(pwdata[12]);
	endproperty
	a_unipolar_write: assert property (p_unipolar_write) else $error("polarity not applied");

	property p_osr_write;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_access && paddr == sdac_pkg::ADDR_CHANNEL_CTL) |=> osr_code == $past({pwdata[11], pwdata[9:8]});
	endproperty
	a_osr_write: assert property (p_osr_write) else $error("oversampling code not applied");

	property p_ovf_sticky;
		@(posedge ref_clk) disable iff (!resetn)
		(ovf_flag && !ovf_clr) |=> ovf_flag;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

	property p_single_stop;
		@(posedge ref_clk) disable iff (!resetn)
		(conv_complete && single_conv_sel) |=> !conv_start;
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("single conversion kept start bit");

	property p_rdata_idle;
		@(posedge ref_clk) disable iff (!resetn)
		!rd_access |=> prdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");

	property p_wait_state;
		@(posedge ref_clk) disable iff (!resetn)
		(psel && penable && !pready) |=> pready;
	endproperty
	a_wait_state: assert property (p_wait_state) else $error("access not completed");

	property p_gctl_hold;
		@(posedge ref_clk) disable iff (!resetn)
		!(wr_access && paddr == sdac_pkg::ADDR_GLOBAL_CTL) |=> $stable(state_reg.gctl);
	endproperty
	a_gctl_hold: assert property (p_gctl_hold) else $error("control word changed without write");
endmodule : sdac_ctrl

// >>> testbench/sigma_delta_adc_control_regs_bench.sv
// sigma_delta_adc_control_regs_bench: self-checking bench for the converter control block
// assumes sdac_pkg and sdac_ctrl are compiled first; the bench is the only APB master
`timescale 1ns/1ps
module sigma_delta_adc_control_regs_bench;
	logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, slv_seen;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] tk;
	logic result_valid, conv_complete, mod_tick, irq;
	logic [23:0] result_data;
	logic low_power_mode_en, ref_generator_on, ref_buffer_on, unipolar_sel;
	logic single_conv_sel, data_format_sel, conv_start;
	logic [1:0] input_buffer_mode;
	logic [2:0] osr_code;
	int err_total, checks_done, ticks_seen, cyc_cnt, seed;

	sdac_ctrl #(.RES_W(24)) i_dut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .main_clock_tick(tk[0]),
		.subsystem_clock_tick(tk[1]), .aux_clock_tick(tk[2]),
		.external_timer_clock_tick(tk[3]), .result_valid, .result_data, .conv_complete,
		.mod_tick, .low_power_mode_en, .ref_generator_on, .ref_buffer_on, .input_buffer_mode,
		.unipolar_sel, .osr_code, .single_conv_sel, .data_format_sel, .conv_start, .irq);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// counting races the main process by one edge; tick windows allow for it
	always @(posedge ref_clk) begin
		if (mod_tick === 1'b1)
			ticks_seen++;
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			err_total++;
			wrap_up();
		end
	end

	task wrap_up();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task chk_cnt(input string nm, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : chk_cnt

	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	// answer is sampled while it stands before the edge that ends the access
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		logic rdy;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(negedge ref_clk);
			rdy = pready;
			q = prdata;
			slv_seen = pslverr;
			@(posedge ref_clk);
		end while (rdy !== 1'b1);
		chk("pready", 32'h1, {31'h0, rdy});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		chk(nm, exp, q);
	endtask : rdc

	task pulse(input logic [23:0] d);
		result_valid <= 1'b1;
		result_data <= d;
		@(posedge ref_clk);
		result_valid <= 1'b0;
		@(posedge ref_clk);
	endtask : pulse

	task chk_irq(input logic e);
		cyc(2);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : chk_irq

	// reserved pre-divider codes run undivided
	function automatic int pre_div(input int c);
		case (c)
			1: return 3;
			2: return 16;
			3: return 48;
			default: return 1;
		endcase
	endfunction : pre_div

	initial begin
		logic [31:0] r;
		logic [15:0] d;
		int c0;
		seed = 32'hCB487711;
		{resetn, psel, penable, pwrite, result_valid, conv_complete} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		tk = 4'h0;
		result_data = 24'h0;
		cyc(5);
		resetn <= 1'b1;
		cyc(1);
		rdc("global reset", sdac_pkg::ADDR_GLOBAL_CTL, 32'h0);
		rdc("channel reset", sdac_pkg::ADDR_CHANNEL_CTL, 32'h0);
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 5; p++) begin
				for (int v = 0; v < 4; v++) begin
					r = $random(seed);
					d = {r[15:12], 3'(p), r[8], 2'(v), 2'(s), r[3:0]};
					wr(sdac_pkg::ADDR_GLOBAL_CTL, {r[31:16], d});
					rdc("global", sdac_pkg::ADDR_GLOBAL_CTL, {16'h0, d & 16'h0FFE});
					chk("power ref", {29'h0, d[8], d[3], d[2]},
						{29'h0, low_power_mode_en, ref_buffer_on, ref_generator_on});
					tk <= 4'h1 << s;
					cyc(4);
					c0 = ticks_seen;
					cyc(4 * pre_div(p) * (1 << v));
					chk_cnt("mod_tick", 3, 5, ticks_seen - c0);
					tk <= ~(4'h1 << s);
					cyc(3);
					c0 = ticks_seen;
					cyc(8);
					chk_cnt("unselected", 0, 0, ticks_seen - c0);
					tk <= 4'h0;
				end
			end
		end
		repeat (16) begin
			r = $random(seed);
			d = r[15:0] & 16'hFFDB;
			wr(sdac_pkg::ADDR_CHANNEL_CTL, {r[31:16], d});
			rdc("channel", sdac_pkg::ADDR_CHANNEL_CTL, {16'h0, d & 16'h7FFE});
			chk("channel outs", {23'h0, d[14:13], d[12], d[11], d[9:8], d[10], d[4], d[1]},
				{23'h0, input_buffer_mode, unipolar_sel, osr_code, single_conv_sel,
				data_format_sel, conv_start});
		end
		wr(sdac_pkg::ADDR_CHANNEL_CTL, 32'h402);
		chk("start", 32'h1, {31'h0, conv_start});
		conv_complete <= 1'b1;
		cyc(1);
		conv_complete <= 1'b0;
		cyc(1);
		chk("single stop", 32'h0, {31'h0, conv_start});
		wr(sdac_pkg::ADDR_CHANNEL_CTL, 32'h8);
		wr(sdac_pkg::ADDR_CORE_CTL, 32'h1);
		wr(sdac_pkg::ADDR_IRQ_ENABLE, 32'h3);
		wr(sdac_pkg::ADDR_GLOBAL_CTL, 32'h0);
		chk_irq(1'b0);
		r = $random(seed);
		pulse(r[23:0]);
		rdc("status", sdac_pkg::ADDR_IRQ_STATUS, 32'h1);
		rdc("channel flag", sdac_pkg::ADDR_CHANNEL_CTL, 32'hC);
		chk_irq(1'b1);
		rdc("result", sdac_pkg::ADDR_RESULT, {16'h0, r[23:8]});
		rdc("status", sdac_pkg::ADDR_IRQ_STATUS, 32'h0);
		pulse(r[23:0]);
		pulse(~r[23:0]);
		rdc("status", sdac_pkg::ADDR_IRQ_STATUS, 32'h3);
		rdc("channel ovf", sdac_pkg::ADDR_CHANNEL_CTL, 32'h2C);
		wr(sdac_pkg::ADDR_IRQ_CLEAR, 32'h1);
		chk_irq(1'b0);
		wr(sdac_pkg::ADDR_GLOBAL_CTL, 32'h2);
		chk_irq(1'b1);
		wr(sdac_pkg::ADDR_CORE_CTL, 32'h0);
		chk_irq(1'b0);
		wr(sdac_pkg::ADDR_CORE_CTL, 32'h1);
		wr(sdac_pkg::ADDR_IRQ_ENABLE, 32'h1);
		chk_irq(1'b0);
		wr(sdac_pkg::ADDR_IRQ_CLEAR, 32'h3);
		rdc("status", sdac_pkg::ADDR_IRQ_STATUS, 32'h0);
		rdc("unmapped", 8'h3C, 32'h0);
		chk("pslverr", 32'h1, {31'h0, slv_seen});
		wr(8'h3C, 32'hFFFF);
		rdc("global kept", sdac_pkg::ADDR_GLOBAL_CTL, 32'h2);
		wrap_up();
	end
endmodule : sigma_delta_adc_control_regs_bench
